// *** include/pwm_audio_dac_regs.svh ***
// register indices, field positions, codes and reset values of the pwm audio dac
`ifndef PWM_AUDIO_DAC_REGS_SVH
`define PWM_AUDIO_DAC_REGS_SVH

`define IDX_CH1_DIVIDER_LOW   30'h00000012
`define IDX_CH1_DIVIDER_HIGH  30'h00000013
`define IDX_SAMPLE_VALUE      30'h00000014
`define IDX_SOUND_CONTROL     30'h00000016
`define IDX_DAC_STATUS        30'h00000018

`define CTRL_DAC_SELECT       0
`define CTRL_INHIBIT          1
`define CTRL_MODE_LSB         2
`define CTRL_MODE_MSB         3
`define CTRL_CLK_LSB          4
`define CTRL_CLK_MSB          6

`define MODE_SINGLE_PIN       2'h0
`define MODE_TWO_ENDED        2'h1
`define MODE_RESERVED         2'h2
`define MODE_PUSH_PULL        2'h3

`define CLK_SYS               3'b000
`define CLK_HALF              3'b?01
`define CLK_QUARTER           3'b?10
`define CLK_EIGHTH            3'b011
`define CLK_DOUBLE            3'b100

`define RST_DIVIDER_LOW       8'h00
`define RST_DIVIDER_HIGH      4'h0
`define RST_SAMPLE_VALUE      8'h00
`define RST_SOUND_CONTROL     7'h00

`define STAT_PENDING          0
`define STAT_ACTIVE_LSB       8
`define STAT_ACTIVE_MSB       15
`define STAT_SEG_LSB          16
`define STAT_SEG_MSB          22

`define PRESCALE_LAST         6'h3F
`define REPEAT_LAST           6'h3F
`define SEGMENT_LAST          7'h7F
`define MAG_MAX               8'h7F
`define SAMPLE_MIN            8'h80

`define TICK_HALF_MASK        4'h1
`define TICK_QUARTER_MASK     4'h3
`define TICK_EIGHTH_MASK      4'h7
`define TICK_SIXTEENTH_MASK   4'hF

`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

// *** include/pwm_audio_dac_pkg.sv ***
// types shared by the pwm audio dac
package pwm_audio_dac_pkg;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } axil_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_type;

    typedef struct packed {
        logic        awHeld;
        logic [31:0] awAddr;
        logic        wHeld;
        logic [7:0]  wData;
        logic        wLane;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic [7:0]  divLow;
        logic [3:0]  divHigh;
        logic [7:0]  sample;
        logic [6:0]  control;
        logic [7:0]  active;
        logic        pending;
        logic [3:0]  tickCnt;
        logic [5:0]  segPre;
        logic [6:0]  segment;
        logic [5:0]  repeatCnt;
        logic        request;
        logic        posPin;
        logic        negPin;
    } state_type;

endpackage

// *** hw/pwm_audio_dac.sv ***
// pwm audio dac: axi4-lite register slave, sound clock divider and pwm pin driver
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "pwm_audio_dac_regs.svh"

module pwm_audio_dac
    import pwm_audio_dac_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire axil_req_type axiReq,
    output axil_rsp_type      axiRsp,
    output logic              positiveOutPin,
    output logic              negativeOutPin,
    output logic              sampleRequest
);

    state_type state_reg;
    state_type state_next;

    always_comb begin
        logic       writeFire;
        logic       readFire;
        logic       hit;
        logic       soundTick;
        logic       segAdvance;
        logic       periodEnd;
        logic       sampleEnd;
        logic       dacOn;
        logic [1:0] mode;
        logic [2:0] clkSel;
        logic [7:0] mag;
        logic [6:0] singleHigh;
        logic       underMag;
        logic       underSingle;
        logic       posDrive;
        logic       negDrive;
        logic [29:0] rdIdx;
        logic [31:0] rdWord;

        writeFire   = 1'b0;
        readFire    = 1'b0;
        hit         = 1'b0;
        soundTick   = 1'b0;
        segAdvance  = 1'b0;
        periodEnd   = 1'b0;
        sampleEnd   = 1'b0;
        mag         = 8'h00;
        singleHigh  = 7'h00;
        underMag    = 1'b0;
        underSingle = 1'b0;
        posDrive    = 1'b0;
        negDrive    = 1'b0;
        rdIdx       = 30'h00000000;
        rdWord      = 32'h00000000;
        state_next  = state_reg;
        state_next.request = 1'b0;

        dacOn  = state_reg.control[`CTRL_DAC_SELECT];
        mode   = state_reg.control[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
        clkSel = state_reg.control[`CTRL_CLK_MSB:`CTRL_CLK_LSB];

        // write channel: address and data may arrive in either order
        if (axiReq.awvalid && !state_reg.awHeld && !state_reg.bValid) begin
            state_next.awHeld = 1'b1;
            state_next.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && !state_reg.wHeld && !state_reg.bValid) begin
            state_next.wHeld = 1'b1;
            state_next.wData = axiReq.wdata[7:0];
            state_next.wLane = axiReq.wstrb[0];
        end
        writeFire = state_reg.awHeld && state_reg.wHeld && !state_reg.bValid;
        if (writeFire) begin
            hit = 1'b1;
            state_next.awHeld = 1'b0;
            state_next.wHeld  = 1'b0;
            state_next.bValid = 1'b1;
            if (state_reg.awAddr[1:0] != 2'h0) begin
                hit = 1'b0;
            end else begin
                unique case (state_reg.awAddr[31:2])
                    `IDX_CH1_DIVIDER_LOW: begin
                        if (state_reg.wLane) begin
                            state_next.divLow = state_reg.wData;
                        end
                    end
                    `IDX_CH1_DIVIDER_HIGH: begin
                        if (state_reg.wLane) begin
                            state_next.divHigh = state_reg.wData[3:0];
                        end
                    end
                    `IDX_SAMPLE_VALUE: begin
                        if (state_reg.wLane) begin
                            state_next.sample  = state_reg.wData;
                            state_next.pending = 1'b0;
                        end
                    end
                    `IDX_SOUND_CONTROL: begin
                        if (state_reg.wLane) begin
                            state_next.control = state_reg.wData[6:0];
                        end
                    end
                    `IDX_DAC_STATUS: begin
                    end
                    default: begin
                        hit = 1'b0;
                    end
                endcase
            end
            state_next.bResp = hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (state_reg.bValid && axiReq.bready) begin
            state_next.bValid = 1'b0;
        end

        // read channel
        readFire = axiReq.arvalid && !state_reg.rValid;
        if (readFire) begin
            rdIdx = axiReq.araddr[31:2];
            state_next.rValid = 1'b1;
            state_next.rResp  = `RESP_OKAY;
            if (axiReq.araddr[1:0] != 2'h0) begin
                state_next.rResp = `RESP_SLVERR;
            end else begin
                unique case (rdIdx)
                    `IDX_CH1_DIVIDER_LOW: begin
                        rdWord[7:0] = state_reg.divLow;
                    end
                    `IDX_CH1_DIVIDER_HIGH: begin
                        rdWord[3:0] = state_reg.divHigh;
                    end
                    `IDX_SAMPLE_VALUE: begin
                        rdWord[7:0] = state_reg.sample;
                    end
                    `IDX_SOUND_CONTROL: begin
                        rdWord[6:0] = state_reg.control;
                    end
                    `IDX_DAC_STATUS: begin
                        rdWord[`STAT_PENDING] = state_reg.pending;
                        rdWord[`STAT_ACTIVE_MSB:`STAT_ACTIVE_LSB] = state_reg.active;
                        rdWord[`STAT_SEG_MSB:`STAT_SEG_LSB] = state_reg.segment;
                    end
                    default: begin
                        state_next.rResp = `RESP_SLVERR;
                    end
                endcase
            end
            state_next.rData = rdWord;
        end
        if (state_reg.rValid && axiReq.rready) begin
            state_next.rValid = 1'b0;
        end

        // sound clock: a full-rate tick stands for twice the system clock
        state_next.tickCnt = state_reg.tickCnt + 4'h1;
        unique casez (clkSel)
            `CLK_DOUBLE: begin
                soundTick = 1'b1;
            end
            `CLK_SYS: begin
                soundTick = (state_reg.tickCnt & `TICK_HALF_MASK) == `TICK_HALF_MASK;
            end
            `CLK_HALF: begin
                soundTick = (state_reg.tickCnt & `TICK_QUARTER_MASK) == `TICK_QUARTER_MASK;
            end
            `CLK_QUARTER: begin
                soundTick = (state_reg.tickCnt & `TICK_EIGHTH_MASK) == `TICK_EIGHTH_MASK;
            end
            `CLK_EIGHTH: begin
                soundTick = state_reg.tickCnt == `TICK_SIXTEENTH_MASK;
            end
            default: begin
                soundTick = (state_reg.tickCnt & `TICK_HALF_MASK) == `TICK_HALF_MASK;
            end
        endcase

        // segment and repeat counters only run in dac function
        if (!dacOn) begin
            state_next.segPre    = state_reg.divLow[5:0];
            state_next.segment   = 7'h00;
            state_next.repeatCnt = {state_reg.divHigh, state_reg.divLow[7:6]};
        end else if (soundTick) begin
            if (state_reg.segPre == `PRESCALE_LAST) begin
                state_next.segPre = state_reg.divLow[5:0];
                segAdvance = 1'b1;
            end else begin
                state_next.segPre = state_reg.segPre + 6'h01;
            end
        end
        if (segAdvance) begin
            state_next.segment = state_reg.segment + 7'h01;
            periodEnd = state_reg.segment == `SEGMENT_LAST;
        end
        if (periodEnd) begin
            if (state_reg.repeatCnt == `REPEAT_LAST) begin
                state_next.repeatCnt = {state_reg.divHigh, state_reg.divLow[7:6]};
                sampleEnd = 1'b1;
            end else begin
                state_next.repeatCnt = state_reg.repeatCnt + 6'h01;
            end
        end
        if (sampleEnd) begin
            state_next.active  = state_next.sample;
            state_next.request = 1'b1;
            state_next.pending = 1'b1;
        end

        // pin waveforms from the sample in use
        mag = state_reg.active[7] ? (~state_reg.active + 8'h01) : state_reg.active;
        if (state_reg.active == `SAMPLE_MIN) begin
            mag = `MAG_MAX; // -128 has no 7-bit magnitude, so it clips
        end
        underMag    = {1'b0, state_reg.segment} < mag;
        singleHigh  = {~state_reg.active[6], state_reg.active[5:0]};
        underSingle = state_reg.segment < singleHigh;

        unique case (mode)
            `MODE_SINGLE_PIN: begin
                posDrive = underSingle;
                negDrive = ~underSingle;
            end
            `MODE_TWO_ENDED: begin
                if (!state_reg.active[7]) begin
                    posDrive = underMag;
                    negDrive = 1'b1;
                end else begin
                    posDrive = 1'b0;
                    negDrive = ~underMag;
                end
            end
            `MODE_PUSH_PULL: begin
                if (!state_reg.active[7]) begin
                    posDrive = underMag;
                    negDrive = 1'b0;
                end else begin
                    posDrive = 1'b0;
                    negDrive = underMag;
                end
            end
            `MODE_RESERVED: begin
                posDrive = 1'b0;
                negDrive = 1'b0;
            end
        endcase

        if (!dacOn || state_reg.control[`CTRL_INHIBIT]) begin
            posDrive = 1'b0;
            negDrive = 1'b0;
        end
        state_next.posPin = posDrive;
        state_next.negPin = negDrive;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg           <= '0;
            state_reg.divLow    <= `RST_DIVIDER_LOW;
            state_reg.divHigh   <= `RST_DIVIDER_HIGH;
            state_reg.sample    <= `RST_SAMPLE_VALUE;
            state_reg.control   <= `RST_SOUND_CONTROL;
            state_reg.bResp     <= `RESP_OKAY;
            state_reg.rResp     <= `RESP_OKAY;
        end else begin
            state_reg <= state_next;
        end
    end

    // handshake outputs straight from state; the write side stalls while a
    // response is waiting, which keeps at most one write in flight
    always_comb begin
        axiRsp.awready = !state_reg.awHeld && !state_reg.bValid;
        axiRsp.wready  = !state_reg.wHeld && !state_reg.bValid;
        axiRsp.bvalid  = state_reg.bValid;
        axiRsp.bresp   = state_reg.bResp;
        axiRsp.arready = !state_reg.rValid;
        axiRsp.rvalid  = state_reg.rValid;
        axiRsp.rdata   = state_reg.rData;
        axiRsp.rresp   = state_reg.rResp;
    end

    assign positiveOutPin = state_reg.posPin;
    assign negativeOutPin = state_reg.negPin;
    assign sampleRequest  = state_reg.request;

endmodule

// *** test/pwm_audio_dac_checker.sv ***
// port-level assertion checker for the pwm audio dac, bound to the design top
`timescale 1ns/10ps
`include "pwm_audio_dac_regs.svh"
module pwm_audio_dac_checker
    import pwm_audio_dac_pkg::*;
(
    input wire logic         mclk,
    input wire logic         reset,
    input wire axil_req_type axiReq,
    input wire axil_rsp_type axiRsp,
    input wire logic         positiveOutPin,
    input wire logic         negativeOutPin,
    input wire logic         sampleRequest
);
    logic [6:0] ctlShadow_reg;
    logic [2:0] ctlAge_reg;
    logic       ctlWrite;
    logic       settled;
    logic       pinsLow;
    logic       arTake;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // shadow of the control register; pins lag a write by two edges, so wait for settling
    assign ctlWrite = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
        && axiReq.awaddr == {`IDX_SOUND_CONTROL, 2'b00} && axiReq.wstrb[0];
    assign settled = ctlAge_reg == 3'h7;
    assign pinsLow = !positiveOutPin && !negativeOutPin;
    assign arTake = axiReq.arvalid && axiRsp.arready;
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctlShadow_reg <= 7'h00;
            ctlAge_reg    <= 3'h0;
        end else if (ctlWrite) begin
            ctlShadow_reg <= axiReq.wdata[6:0];
            ctlAge_reg    <= 3'h0;
        end else if (!settled) begin
            ctlAge_reg <= ctlAge_reg + 3'h1;
        end
    end
    chk_reset_idle: assert property ($fell(reset) |-> pinsLow && !sampleRequest)
        else $error("pins or request not idle after reset");
    chk_request_pulse: assert property (sampleRequest |=> !sampleRequest)
        else $error("sample request longer than one cycle");
    chk_bresp_hold: assert property (axiRsp.bvalid && !axiReq.bready
        |=> axiRsp.bvalid && $stable(axiRsp.bresp)) else $error("write response dropped");
    chk_write_answer: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid
        && axiRsp.wready |-> ##[1:2] axiRsp.bvalid) else $error("write not answered");
    chk_read_answer: assert property (arTake |=> axiRsp.rvalid) else $error("read not answered");
    chk_unmapped_error: assert property (arTake && axiReq.araddr == 32'h00000044
        |=> axiRsp.rresp == `RESP_SLVERR && axiRsp.rdata == 32'h00000000)
        else $error("unmapped read not refused");
    chk_dac_off: assert property (settled && !ctlShadow_reg[0] |-> pinsLow && !sampleRequest)
        else $error("activity while dac function off");
    chk_inhibit_low: assert property (settled && ctlShadow_reg[1] |-> pinsLow)
        else $error("pins driven while inhibited");
    chk_reserved_low: assert property (settled && ctlShadow_reg[3:2] == 2'h2 |-> pinsLow)
        else $error("pins driven in reserved mode");
    chk_single_inverse: assert property (settled && ctlShadow_reg[3:0] == 4'h1
        |-> negativeOutPin != positiveOutPin) else $error("single-pin pins not inverse");
    chk_two_ended: assert property (settled && ctlShadow_reg[3:0] == 4'h5
        |-> !(positiveOutPin && !negativeOutPin)) else $error("two-ended pin pair illegal");
    chk_push_excl: assert property (settled && ctlShadow_reg[3:0] == 4'hD
        |-> !(positiveOutPin && negativeOutPin)) else $error("push-pull pins both high");
    cov_request: cover property (sampleRequest);
    cov_single: cover property (settled && ctlShadow_reg[3:0] == 4'h1 && positiveOutPin);
    cov_push: cover property (settled && ctlShadow_reg[3:0] == 4'hD && negativeOutPin);
endmodule

bind pwm_audio_dac pwm_audio_dac_checker checker_inst (.mclk(mclk), .reset(reset),
    .axiReq(axiReq), .axiRsp(axiRsp), .positiveOutPin(positiveOutPin),
    .negativeOutPin(negativeOutPin), .sampleRequest(sampleRequest));

// *** test/speaker_load.sv ***
// two-pin load model: counts high cycles of each pin over one sample period
`timescale 1ns/10ps
module speaker_load (
    input  wire logic  mclk,
    input  wire logic  posDrive,
    input  wire logic  negDrive,
    input  wire logic  periodMark,
    output logic [7:0] posHigh,
    output logic [7:0] negHigh,
    output logic       reportValid
);
    logic [7:0] posAcc = 8'h00;
    logic [7:0] negAcc = 8'h00;
    // a pure load: it drives nothing back, so the pins and the period mark alone decide what it reports
    always @(posedge mclk) begin
        reportValid <= periodMark;
        if (periodMark) begin
            posHigh <= posAcc + {7'h00, posDrive};
            negHigh <= negAcc + {7'h00, negDrive};
            posAcc  <= 8'h00;
            negAcc  <= 8'h00;
        end else begin
            posAcc <= posAcc + {7'h00, posDrive};
            negAcc <= negAcc + {7'h00, negDrive};
        end
    end
endmodule

// *** test/testbench.sv ***
// self-checking testbench for the pwm audio dac
`timescale 1ns/10ps
`include "pwm_audio_dac_regs.svh"
module testbench
    import pwm_audio_dac_pkg::*;
;
    localparam logic [31:0] divLoAddr = {`IDX_CH1_DIVIDER_LOW, 2'b00};
    localparam logic [31:0] divHiAddr = {`IDX_CH1_DIVIDER_HIGH, 2'b00};
    localparam logic [31:0] sampleAddr = {`IDX_SAMPLE_VALUE, 2'b00};
    localparam logic [31:0] ctlAddr = {`IDX_SOUND_CONTROL, 2'b00};
    localparam logic [31:0] statAddr = {`IDX_DAC_STATUS, 2'b00};
    logic         mclk = 1'b0;
    logic         reset = 1'b1;
    axil_req_type axiReq = '0;
    axil_rsp_type axiRsp;
    logic         positiveOutPin;
    logic         negativeOutPin;
    logic         sampleRequest;
    logic [7:0]   posHigh;
    logic [7:0]   negHigh;
    logic         reportValid;
    logic [33:0]  rdQ[$];
    logic [1:0]   bQ[$];
    logic [15:0]  pinQ[$];
    logic [31:0]  gapQ[$];
    logic [31:0]  gap = 32'h0;
    logic [31:0]  rng = 32'h73FA8A23;
    logic [7:0]   sample;
    logic         output_inhibit;
    logic [7:0]   samples[6] = '{8'h00, 8'h3F, 8'hC0, 8'h7F, 8'h81, 8'h80};
    logic [1:0]   modes[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    logic [2:0]   sels[8] = '{3'b100, 3'b000, 3'b001, 3'b101, 3'b010, 3'b110, 3'b011, 3'b111};
    logic [31:0]  mults[8] = '{1, 2, 4, 4, 8, 8, 16, 2};
    int           err_count = 0;
    int           checks_done = 0;
    int           cycles = 0;

    pwm_audio_dac uut (.mclk(mclk), .reset(reset), .axiReq(axiReq), .axiRsp(axiRsp),
        .positiveOutPin(positiveOutPin), .negativeOutPin(negativeOutPin),
        .sampleRequest(sampleRequest));
    speaker_load load (.mclk(mclk), .posDrive(positiveOutPin), .negDrive(negativeOutPin),
        .periodMark(sampleRequest), .posHigh(posHigh), .negHigh(negHigh),
        .reportValid(reportValid));

    always #2.5 mclk = ~mclk;

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // expected high-cycle counts {positive, negative} over one 128-segment period
    function automatic logic [15:0] expectPins(input logic [1:0] mode, input logic [7:0] a);
        logic [7:0] mag;
        logic [7:0] lev;
        mag = a[7] ? ((a == 8'h80) ? 8'h7F : 8'h00 - a) : a;
        lev = {1'b0, ~a[6], a[5:0]};
        case (mode)
            2'h0: return {lev, 8'h80 - lev};
            2'h1: return a[7] ? {8'h00, 8'h80 - mag} : {a, 8'h80};
            2'h3: return a[7] ? {8'h00, mag} : {a, 8'h00};
            default: return 16'h0000;
        endcase
    endfunction

    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] want);
        checks_done++;
        if (seen !== want) begin
            err_count++;
            $display("BAD %s expected %0h seen %0h", what, want, seen);
        end
    endtask

    task automatic axiWrite(input logic [31:0] addr, input logic [7:0] data,
                            input logic [3:0] strb, input logic [1:0] resp);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        bQ.push_back(resp);
        axiReq.awaddr  <= addr;
        axiReq.wdata   <= {24'h000000, data};
        axiReq.wstrb   <= strb;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid  <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge mclk);
            if (!awDone && axiRsp.awready) begin
                awDone = 1'b1;
                axiReq.awvalid <= 1'b0;
            end
            if (!wDone && axiRsp.wready) begin
                wDone = 1'b1;
                axiReq.wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (!axiRsp.bvalid);
    endtask

    task automatic axiRead(input logic [31:0] addr, input logic [33:0] want);
        rdQ.push_back(want);
        axiReq.araddr  <= addr;
        axiReq.arvalid <= 1'b1;
        do @(posedge mclk); while (!axiRsp.arready);
        axiReq.arvalid <= 1'b0;
        do @(posedge mclk); while (!axiRsp.rvalid);
    endtask

    task automatic waitReq(input int n);
        repeat (n) do @(posedge mclk); while (!sampleRequest);
    endtask

    // the period cut by a setting change is skipped; the note goes in off a request edge
    task automatic measureGap(input logic [31:0] want);
        waitReq(1);
        @(posedge mclk);
        gapQ.push_back(want);
        waitReq(1);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // watcher: every bus answer is matched against the oldest note; pin reports and gaps only while a note waits
    always @(posedge mclk) begin
        cycles++;
        gap++;
        if (axiRsp.bvalid && axiReq.bready)
            check("bresp", {32'h0, axiRsp.bresp}, {32'h0, bQ.pop_front()});
        if (axiRsp.rvalid && axiReq.rready)
            check("rdata", {axiRsp.rresp, axiRsp.rdata}, rdQ.pop_front());
        if (reportValid && pinQ.size() > 0)
            check("pins", {18'h0, posHigh, negHigh}, {18'h0, pinQ.pop_front()});
        if (sampleRequest) begin
            if (gapQ.size() > 0)
                check("gap", {2'h0, gap}, {2'h0, gapQ.pop_front()});
            gap = 32'h0;
        end
        if (cycles == 100000) begin
            err_count++;
            tally_and_finish();
        end
    end

    initial begin
        axiReq.bready <= 1'b1;
        axiReq.rready <= 1'b1;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        // fresh registers read zero; indices 0x15, 0x17 and 0x19 are holes
        foreach (sels[i]) axiRead({24'h0, 8'h48 + 8'(i * 4)},
            (i == 3 || i == 5 || i == 7) ? {2'h2, 32'h0} : 34'h0);
        axiRead(32'h00000044, {2'h2, 32'h0});
        axiRead(32'h00000049, {2'h2, 32'h0});
        axiWrite(32'h00000044, 8'h11, 4'hF, `RESP_SLVERR);
        axiWrite(statAddr, 8'hFF, 4'hF, `RESP_OKAY);
        axiWrite(ctlAddr, 8'h55, 4'h0, `RESP_OKAY);
        axiRead(ctlAddr, 34'h0);
        axiWrite(divHiAddr, 8'h0F, 4'h1, `RESP_OKAY);
        axiWrite(divLoAddr, 8'hFF, 4'h1, `RESP_OKAY);
        axiRead(divHiAddr, 34'h0000000F);
        // the fast sound clock stands in for the doubled system clock
        foreach (sels[i]) begin
            axiWrite(ctlAddr, {1'b0, sels[i], 4'h1}, 4'h1, `RESP_OKAY);
            measureGap(32'h80 * mults[i]);
        end
        axiWrite(ctlAddr, 8'h41, 4'h1, `RESP_OKAY);
        axiWrite(divLoAddr, 8'h3F, 4'h1, `RESP_OKAY);
        measureGap(32'h200);
        axiWrite(divLoAddr, 8'hFE, 4'h1, `RESP_OKAY);
        measureGap(32'h100);
        axiWrite(divLoAddr, 8'hFF, 4'h1, `RESP_OKAY);
        foreach (modes[m]) begin
            for (int k = 0; k < 8; k++) begin
                sample = (k < 6) ? samples[k] : rng[7:0];
                rng = xorshift(rng);
                output_inhibit = (k == 7);
                axiWrite(ctlAddr, {1'b0, 3'b100, modes[m], output_inhibit, 1'b1}, 4'h1, `RESP_OKAY);
                axiWrite(sampleAddr, sample, 4'h1, `RESP_OKAY);
                waitReq(3);
                pinQ.push_back(output_inhibit ? 16'h0000 : expectPins(modes[m], sample));
            end
        end
        waitReq(2);
        axiWrite(ctlAddr, 8'h00, 4'h1, `RESP_OKAY);
        repeat (20) @(posedge mclk);
        check("notes left", 34'(rdQ.size() + bQ.size() + pinQ.size() + gapQ.size()), 34'h0);
        tally_and_finish();
    end
endmodule
